// ==== asmc_params.svh ====
// constants for the async serial port with modem control
`ifndef ASMC_PARAMS_SVH
`define ASMC_PARAMS_SVH
`define ASMC_ADDR_DATA 3'h0
`define ASMC_ADDR_IER 3'h1
`define ASMC_ADDR_ISR 3'h2
`define ASMC_ADDR_LCR 3'h3
`define ASMC_ADDR_MCR 3'h4
`define ASMC_ADDR_LSR 3'h5
`define ASMC_ADDR_MSR 3'h6
`define ASMC_ADDR_SPR 3'h7
`define ASMC_IER_SPECIAL 5
`define ASMC_LCR_BREAK 6
`define ASMC_LCR_DLAB 7
`define ASMC_MCR_DTR 0
`define ASMC_MCR_RTS 1
`define ASMC_MCR_SRST 2
`define ASMC_MCR_INTEN 3
`define ASMC_MCR_LOOP 4
`define ASMC_MCR_PDOWN 7
`define ASMC_IER_MASK 8'h2f
`define ASMC_MCR_MASK 8'h9f
`define ASMC_IER_RST 8'h00
`define ASMC_LCR_RST 8'h00
`define ASMC_MCR_RST 8'h00
`define ASMC_DIV_RST 8'h00
`define ASMC_BIT_TICKS 6'd16
`define ASMC_STOP15_TICKS 6'd24
`define ASMC_STOP2_TICKS 6'd32
`define ASMC_START_TICKS 6'd8
`define ASMC_ISR_LINE 3'b110
`define ASMC_ISR_RXD 3'b100
`define ASMC_ISR_THR 3'b010
`define ASMC_ISR_MODEM 3'b000
`define ASMC_ISR_NONE 3'b001
`endif

// ==== asmc_pkg.sv ====
// types and shared helpers of the async serial port
package asmc_pkg;
  typedef struct packed {
    logic par_force;
    logic par_even;
    logic par_en;
    logic stop2;
    logic [1:0] len;
  } asmc_fmt_t;
  typedef struct packed {
    logic brk;
    logic ferr;
    logic perr;
    logic [7:0] data;
  } asmc_rx_res_t;
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } asmc_modem_t;
  typedef enum logic [2:0] {
    ASMC_IDLE = 3'b000,
    ASMC_START = 3'b001,
    ASMC_DATA = 3'b010,
    ASMC_PARITY = 3'b011,
    ASMC_STOP = 3'b100
  } asmc_state_t;

  // index of the last data bit for a length code
  function automatic logic [2:0] asmc_last_bit(input logic [1:0] len);
    asmc_last_bit = {1'b1, len};
  endfunction : asmc_last_bit

  function automatic logic asmc_par_bit(input logic [7:0] data, input asmc_fmt_t fmt);
    logic [7:0] m;
    m = 8'hff >> (3'd3 - {1'b0, fmt.len});
    if (fmt.par_force) begin
      asmc_par_bit = ~fmt.par_even;
    end else begin
      asmc_par_bit = fmt.par_even ? ^(data & m) : ~^(data & m);
    end
  endfunction : asmc_par_bit
endpackage : asmc_pkg

// ==== asmc_tx.sv ====
// serial transmitter, advances on the 16x tick
`timescale 1ns/1ps
`include "asmc_params.svh"
module asmc_tx import asmc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic start,
  input wire logic [7:0] data,
  input wire asmc_fmt_t fmt,
  output logic line,
  output logic busy
);
  asmc_state_t state;
  logic [7:0] shreg;
  logic [5:0] tcnt;
  logic [2:0] bitn;
  logic par;
  wire logic [5:0] stop_ticks = !fmt.stop2 ? `ASMC_BIT_TICKS :
    (fmt.len == 2'b00) ? `ASMC_STOP15_TICKS : `ASMC_STOP2_TICKS;
  wire logic [5:0] last_tick = (state == ASMC_STOP) ? 6'(stop_ticks - 6'd1) :
    6'(`ASMC_BIT_TICKS - 6'd1);
  wire logic bit_end = tick && (tcnt == last_tick);
  wire logic last_data = (bitn == asmc_last_bit(fmt.len));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ASMC_IDLE;
      shreg <= 8'h00;
      tcnt <= 6'h00;
      bitn <= 3'h0;
      par <= 1'b0;
      line <= 1'b1;
      busy <= 1'b0;
    end else begin
      if (tick && !bit_end) begin
        tcnt <= 6'(tcnt + 6'd1);
      end else if (bit_end) begin
        tcnt <= 6'h00;
      end
      case (state)
        ASMC_IDLE: begin
          if (start) begin
            shreg <= data;
            par <= asmc_par_bit(data, fmt);
            state <= ASMC_START;
            line <= 1'b0;
            tcnt <= 6'h00;
            bitn <= 3'h0;
            busy <= 1'b1;
          end
        end
        ASMC_START: begin
          if (bit_end) begin
            state <= ASMC_DATA;
            line <= shreg[0];
          end
        end
        ASMC_DATA: begin
          if (bit_end && last_data) begin
            state <= fmt.par_en ? ASMC_PARITY : ASMC_STOP;
            line <= fmt.par_en ? par : 1'b1;
          end else if (bit_end) begin
            bitn <= 3'(bitn + 3'd1);
            shreg <= shreg >> 1;
            line <= shreg[1];
          end
        end
        ASMC_PARITY: begin
          if (bit_end) begin
            state <= ASMC_STOP;
            line <= 1'b1;
          end
        end
        ASMC_STOP: begin
          if (bit_end) begin
            state <= ASMC_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= ASMC_IDLE;
          line <= 1'b1;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule : asmc_tx

// ==== asmc_rx.sv ====
// serial receiver with start-bit check
`timescale 1ns/1ps
`include "asmc_params.svh"
module asmc_rx import asmc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic line,
  input wire asmc_fmt_t fmt,
  output logic done,
  output asmc_rx_res_t res
);
  asmc_state_t state;
  logic [7:0] shreg;
  logic [5:0] tcnt;
  logic [2:0] bitn;
  logic prev;
  logic pbit;
  wire logic [2:0] last = asmc_last_bit(fmt.len);
  wire logic [7:0] aligned = shreg >> (3'd7 - last);
  wire logic [5:0] last_tick = (state == ASMC_START) ? 6'(`ASMC_START_TICKS - 6'd1) :
    6'(`ASMC_BIT_TICKS - 6'd1);
  wire logic bit_end = tick && (tcnt == last_tick);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ASMC_IDLE;
      shreg <= 8'h00;
      tcnt <= 6'h00;
      bitn <= 3'h0;
      prev <= 1'b1;
      pbit <= 1'b0;
      done <= 1'b0;
      res <= '0;
    end else begin
      prev <= line;
      done <= 1'b0;
      if (tick && !bit_end) begin
        tcnt <= 6'(tcnt + 6'd1);
      end else if (bit_end) begin
        tcnt <= 6'h00;
      end
      case (state)
        ASMC_IDLE: begin
          if (prev && !line) begin
            state <= ASMC_START;
            tcnt <= 6'h00;
          end
        end
        ASMC_START: begin
          if (bit_end) begin
            state <= line ? ASMC_IDLE : ASMC_DATA;
            bitn <= 3'h0;
            shreg <= 8'h00;
          end
        end
        ASMC_DATA: begin
          if (bit_end) begin
            shreg <= {line, shreg[7:1]};
            bitn <= 3'(bitn + 3'd1);
            if (bitn == last) begin
              state <= fmt.par_en ? ASMC_PARITY : ASMC_STOP;
            end
          end
        end
        ASMC_PARITY: begin
          if (bit_end) begin
            pbit <= line;
            state <= ASMC_STOP;
          end
        end
        ASMC_STOP: begin
          if (bit_end) begin
            state <= ASMC_IDLE;
            done <= 1'b1;
            res.data <= aligned;
            res.perr <= fmt.par_en && (pbit != asmc_par_bit(aligned, fmt));
            res.ferr <= !line;
            res.brk <= !line && (aligned == 8'h00) && !(fmt.par_en && pbit);
          end
        end
        default: begin
          state <= ASMC_IDLE;
        end
      endcase
    end
  end
endmodule : asmc_rx

// ==== asmc_top.sv ====
// async serial port with modem control: host registers, baud generator, status
`timescale 1ns/1ps
`include "asmc_params.svh"
// Notes on behaviour
// - holding-empty flag sets when shifter takes byte
// - start bit checked low at mid bit
// - divisor makes a 16x tick
// - enable bits 0-3 gate four sources
// - bit 5 special mode unlocks powerdown, softreset
// - interrupt code reports highest pending source
// - status bit 0 low when pending
// - length code selects five to eight bits
// - stop bit one, one-and-half or two
// - parity enable, even select, forced parity
// - break bit holds serial output low outside loopback
// - divisor access remaps addresses zero and one
// - control bits drive dtr and rts low
// - soft reset bit drives reset output high
// - interrupt pin floats unless enable bit set
// - loopback mutes line, feeds receiver internally
// - loopback modem changes come from control bits
// - power down stops baud generator
// - line status flags and empty bits
// - modem deltas set on change (ring only when it goes inactive), clear on read
// - modem status upper bits show line levels, or the control bits in loopback
// - reset values of registers and pins
// - scratch byte reads back unchanged
module asmc_top import asmc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic rx,
  output logic tx,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  output logic dtr_n,
  output logic rts_n,
  output logic rst_out,
  output logic int_out,
  output logic int_oe_n
);
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // host strobes
  logic rd_prev;
  logic wr_prev;
  wire logic rd_act = !cs_n && !ior_n;
  wire logic wr_act = !cs_n && !iow_n;
  wire logic rd_go = rd_act && !rd_prev;
  wire logic wr_go = wr_act && !wr_prev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      rd_prev <= rd_act;
      wr_prev <= wr_act;
    end
  end

  // registers
  logic [7:0] interrupt_mask;
  logic [7:0] frame_format_control;
  logic [7:0] modem_line_control;
  logic [7:0] dll;
  logic [7:0] baud_divisor_high;
  logic [7:0] scratch_byte;
  logic [7:0] transmit_data_byte;
  logic [7:0] receive_data_byte;

  wire logic dlab = frame_format_control[`ASMC_LCR_DLAB];
  wire logic at_data = (addr == `ASMC_ADDR_DATA);
  wire logic at_ier = (addr == `ASMC_ADDR_IER);
  wire logic wr_thr = wr_go && at_data && !dlab;
  wire logic wr_dll = wr_go && at_data && dlab;
  wire logic wr_ier = wr_go && at_ier && !dlab;
  wire logic wr_dlm = wr_go && at_ier && dlab;
  wire logic wr_lcr = wr_go && (addr == `ASMC_ADDR_LCR);
  wire logic wr_mcr = wr_go && (addr == `ASMC_ADDR_MCR);
  wire logic wr_spr = wr_go && (addr == `ASMC_ADDR_SPR);
  wire logic rd_rhr = rd_go && at_data && !dlab;
  wire logic rd_isr = rd_go && (addr == `ASMC_ADDR_ISR);
  wire logic rd_lsr = rd_go && (addr == `ASMC_ADDR_LSR);
  wire logic rd_msr = rd_go && (addr == `ASMC_ADDR_MSR);

  wire logic special = interrupt_mask[`ASMC_IER_SPECIAL];
  wire logic loop = modem_line_control[`ASMC_MCR_LOOP];
  wire logic pdown = special && modem_line_control[`ASMC_MCR_PDOWN];
  wire asmc_fmt_t fmt = asmc_fmt_t'(frame_format_control[5:0]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_mask <= `ASMC_IER_RST;
      frame_format_control <= `ASMC_LCR_RST;
      modem_line_control <= `ASMC_MCR_RST;
      dll <= `ASMC_DIV_RST;
      baud_divisor_high <= `ASMC_DIV_RST;
      scratch_byte <= 8'h00;
      transmit_data_byte <= 8'h00;
    end else begin
      if (wr_ier) interrupt_mask <= data_in & `ASMC_IER_MASK;
      if (wr_lcr) frame_format_control <= data_in;
      if (wr_mcr) modem_line_control <= data_in & `ASMC_MCR_MASK;
      if (wr_dll) dll <= data_in;
      if (wr_dlm) baud_divisor_high <= data_in;
      if (wr_spr) scratch_byte <= data_in;
      if (wr_thr) transmit_data_byte <= data_in;
    end
  end

  // baud generator, zero divisor holds it still
  logic [15:0] div_cnt;
  logic tick;
  wire logic [15:0] divisor = {baud_divisor_high, dll};
  wire logic baud_run = (divisor != 16'h0000) && !pdown;
  wire logic div_wrap = (div_cnt >= 16'(divisor - 16'h0001));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (!baud_run) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? 16'h0000 : 16'(div_cnt + 16'h0001);
      tick <= div_wrap;
    end
  end

  // transmitter
  logic thre;
  logic thri_pend;
  logic tx_line;
  logic tx_busy;
  wire logic tx_start = !thre && !tx_busy;

  asmc_tx u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .start(tx_start),
    .data(transmit_data_byte),
    .fmt(fmt),
    .line(tx_line),
    .busy(tx_busy)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thre <= 1'b1;
    end else if (wr_thr) begin
      thre <= 1'b0;
    end else if (tx_start) begin
      thre <= 1'b1;
    end
  end

  // receiver
  logic rx_done;
  asmc_rx_res_t rx_res;
  wire logic rx_in = loop ? tx_line : rx;

  asmc_rx u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .line(rx_in),
    .fmt(fmt),
    .done(rx_done),
    .res(rx_res)
  );

  // line status flags, a new event wins over a read
  logic dr;
  logic ovr;
  logic perr;
  logic ferr;
  logic brk;
  wire logic temt = thre && !tx_busy;
  wire logic [7:0] serial_line_state = {1'b0, temt, thre, brk, ferr, perr, ovr, dr};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_data_byte <= 8'h00;
      dr <= 1'b0;
      ovr <= 1'b0;
      perr <= 1'b0;
      ferr <= 1'b0;
      brk <= 1'b0;
    end else begin
      if (rx_done) receive_data_byte <= rx_res.data;
      dr <= rx_done || (dr && !rd_rhr);
      ovr <= (rx_done && dr && !rd_rhr) || (ovr && !rd_lsr);
      perr <= (rx_done && rx_res.perr) || (perr && !rd_lsr);
      ferr <= (rx_done && rx_res.ferr) || (ferr && !rd_lsr);
      brk <= (rx_done && rx_res.brk) || (brk && !rd_lsr);
    end
  end

  // modem status
  logic primed;
  asmc_modem_t mprev;
  logic [3:0] delta;
  wire asmc_modem_t pins = asmc_modem_t'(~{cd_n, ri_n, dsr_n, cts_n});
  wire asmc_modem_t looped = '{cd: modem_line_control[`ASMC_MCR_INTEN], ri: modem_line_control[`ASMC_MCR_SRST],
    dsr: modem_line_control[`ASMC_MCR_DTR], cts: modem_line_control[`ASMC_MCR_RTS]};
  wire asmc_modem_t msrc = loop ? looped : pins;
  wire logic [3:0] mchg = !primed ? 4'h0 : {msrc.cd ^ mprev.cd, mprev.ri && !msrc.ri,
    msrc.dsr ^ mprev.dsr, msrc.cts ^ mprev.cts};
  wire logic [7:0] modem_line_state = {msrc, delta};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primed <= 1'b0;
      mprev <= '0;
      delta <= 4'h0;
    end else begin
      primed <= 1'b1;
      mprev <= msrc;
      delta <= mchg | (rd_msr ? 4'h0 : delta);
    end
  end

  // interrupt priority
  wire logic lsi = interrupt_mask[2] && (ovr || perr || ferr || brk);
  wire logic rdi = interrupt_mask[0] && dr;
  wire logic thi = interrupt_mask[1] && thri_pend && thre;
  wire logic msi = interrupt_mask[3] && (delta != 4'h0);
  wire logic [2:0] isr_code = lsi ? `ASMC_ISR_LINE :
    rdi ? `ASMC_ISR_RXD :
    thi ? `ASMC_ISR_THR :
    msi ? `ASMC_ISR_MODEM : `ASMC_ISR_NONE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thri_pend <= 1'b0;
    end else if (tx_start) begin
      thri_pend <= 1'b1;
    end else if (wr_thr || (rd_isr && isr_code == `ASMC_ISR_THR)) begin
      thri_pend <= 1'b0;
    end
  end

  // read data selection
  wire logic [7:0] rd_mux =
    at_data ? (dlab ? dll : receive_data_byte) :
    at_ier ? (dlab ? baud_divisor_high : interrupt_mask) :
    (addr == `ASMC_ADDR_ISR) ? {5'h00, isr_code} :
    (addr == `ASMC_ADDR_LCR) ? frame_format_control :
    (addr == `ASMC_ADDR_MCR) ? modem_line_control :
    (addr == `ASMC_ADDR_LSR) ? serial_line_state :
    (addr == `ASMC_ADDR_MSR) ? modem_line_state : scratch_byte;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      if (rd_go) data_out <= rd_mux;
      data_oe_n <= !rd_act;
    end
  end

  // pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx <= 1'b1;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      rst_out <= 1'b1;
      int_out <= 1'b0;
      int_oe_n <= 1'b1;
    end else begin
      tx <= loop ? 1'b1 : (frame_format_control[`ASMC_LCR_BREAK] ? 1'b0 : tx_line);
      dtr_n <= !modem_line_control[`ASMC_MCR_DTR];
      rts_n <= !modem_line_control[`ASMC_MCR_RTS];
      rst_out <= special && modem_line_control[`ASMC_MCR_SRST];
      int_out <= !isr_code[0];
      int_oe_n <= !modem_line_control[`ASMC_MCR_INTEN];
    end
  end
endmodule : asmc_top

// ==== asmc_top_props.sv ====
// checker for the async serial port top, bound at the foot
`timescale 1ns/1ps
module asmc_top_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic tx,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic rst_out,
  input wire logic int_out,
  input wire logic int_oe_n
);
  logic wr_q;
  logic rd_q;
  logic dlab_q;
  logic [7:0] spr_q;
  wire wr_go = !cs_n && !iow_n && !wr_q;
  wire rd_go = !cs_n && !ior_n && !rd_q;
  // scratch copy follows the register, cleared by reset like it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      dlab_q <= 1'b0;
      spr_q <= 8'h00;
    end else begin
      wr_q <= !cs_n && !iow_n;
      rd_q <= !cs_n && !ior_n;
      dlab_q <= (wr_go && addr == 3'h3) ? data_in[7] : dlab_q;
      spr_q <= (wr_go && addr == 3'h7) ? data_in : spr_q;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr(logic [2:0] a);
    wr_go && addr == a;
  endsequence
  sequence s_rd(logic [2:0] a);
    rd_go && addr == a;
  endsequence
  property p_reset;
    $rose(nrst) |-> (tx && dtr_n && rts_n && int_oe_n && rst_out) ##1 rst_out;
  endproperty
  a_reset: assert property (p_reset) else $error("pins not at reset level");
  property p_dtr;
    s_wr(3'h4) |-> ##[1:3] (dtr_n == !data_in[0] && rts_n == !data_in[1]);
  endproperty
  a_dtr: assert property (p_dtr) else $error("modem outputs wrong");
  property p_float;
    s_wr(3'h4) |-> ##[1:3] (int_oe_n == !data_in[3]);
  endproperty
  a_float: assert property (p_float) else $error("interrupt enable pin wrong");
  property p_mark;
    s_wr(3'h4) ##0 data_in[4] |-> ##[1:3] tx [*6];
  endproperty
  a_mark: assert property (p_mark) else $error("serial out not mark in loopback");
  property p_break;
    s_wr(3'h3) ##0 data_in[6] |-> ##[1:4] !tx [*5];
  endproperty
  a_break: assert property (p_break) else $error("break not held low");
  property p_mask;
    s_wr(3'h1) ##0 (!dlab_q && data_in[3:0] == 4'h0) |-> ##2 !int_out [*3];
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt raised");
  property p_spr;
    s_rd(3'h7) |-> ##1 (data_out == spr_q);
  endproperty
  a_spr: assert property (p_spr) else $error("scratch readback wrong");
  property p_isr;
    s_rd(3'h2) |-> ##1 (data_out[7:3] == 5'h0 &&
      data_out[2:0] inside {3'b110, 3'b100, 3'b010, 3'b000, 3'b001});
  endproperty
  a_isr: assert property (p_isr) else $error("bad interrupt code");
endmodule : asmc_top_props
bind asmc_top asmc_top_props u_props (.clk(clk), .nrst(nrst), .cs_n(cs_n), .ior_n(ior_n),
  .iow_n(iow_n), .addr(addr), .data_in(data_in), .data_out(data_out), .tx(tx),
  .dtr_n(dtr_n), .rts_n(rts_n), .rst_out(rst_out), .int_out(int_out), .int_oe_n(int_oe_n));

// ==== asmc_line_model.sv ====
// far-end serial line: sends frames on rx, decodes frames seen on tx
`timescale 1ns/1ps
module asmc_line_model (
  input wire logic clk,
  input wire logic tx,
  output logic rx
);
  int bit_cyc = 16;
  int nbits = 8;
  bit par_en = 1'b0;
  int cyc = 0;
  logic [9:0] got[$];
  int t0[$];
  // released line sits at mark
  initial rx = 1'b1;
  always @(posedge clk) cyc++;
  task automatic hold(input logic b, input int c);
    rx = b;
    repeat (c) @(negedge clk);
  endtask : hold
  task automatic low(input int c);
    @(negedge clk);
    hold(1'b0, c);
    rx = 1'b1;
  endtask : low
  task automatic send(input logic [7:0] d, input int n, input bit pe, input logic pb,
    input logic stp);
    @(negedge clk);
    hold(1'b0, bit_cyc);
    for (int i = 0; i < n; i++) begin
      hold(d[i], bit_cyc);
    end
    if (pe) begin
      hold(pb, bit_cyc);
    end
    hold(stp, bit_cyc);
    rx = 1'b1;
  endtask : send
  // frame decode: {stop, parity, data}, sampled mid bit
  always begin
    logic [9:0] v;
    @(negedge tx);
    t0.push_back(cyc);
    v = '0;
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_cyc) @(posedge clk);
      v[i] = tx;
    end
    if (par_en) begin
      repeat (bit_cyc) @(posedge clk);
      v[8] = tx;
    end
    repeat (bit_cyc) @(posedge clk);
    v[9] = tx;
    got.push_back(v);
  end
endmodule : asmc_line_model

// ==== asmc_top_tb.sv ====
// self-checking testbench for the async serial port top
`timescale 1ns/1ps
module asmc_top_tb;
  logic clk, nrst, cs_n, ior_n, iow_n, rx, tx, data_oe_n, dtr_n, rts_n, rst_out;
  logic int_out, int_oe_n;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, v, d, l, e;
  logic [3:0] mdm_n, p;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int dv, ex;
  asmc_top dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .rx(rx),
    .tx(tx), .cts_n(mdm_n[0]), .dsr_n(mdm_n[1]), .ri_n(mdm_n[2]), .cd_n(mdm_n[3]),
    .dtr_n(dtr_n), .rts_n(rts_n), .rst_out(rst_out), .int_out(int_out), .int_oe_n(int_oe_n));
  asmc_line_model line (.clk(clk), .tx(tx), .rx(rx));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [7:0] xe, input logic [7:0] g);
    n_tests++;
    if (g !== xe) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, xe, g);
    end
  endtask : chk
  task automatic acc(input bit w, input logic [2:0] a, input logic [7:0] dw);
    @(negedge clk);
    addr = a;
    data_in = dw;
    cs_n = 1'b0;
    iow_n = !w;
    ior_n = w;
    repeat (3) @(negedge clk);
    cs_n = 1'b1;
    iow_n = 1'b1;
    ior_n = 1'b1;
    v = data_out;
    @(negedge clk);
  endtask : acc
  task automatic wr(input logic [2:0] a, input logic [7:0] dw);
    acc(1'b1, a, dw);
  endtask : wr
  task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] xe);
    acc(1'b0, a, 8'h00);
    chk(nm, xe, v);
  endtask : rdc
  task automatic poll(input logic [7:0] m);
    int k = 0;
    acc(1'b0, 3'h5, 8'h00);
    while ((v & m) == 8'h00 && k < 300) begin
      acc(1'b0, 3'h5, 8'h00);
      k++;
    end
    chk("lsr_poll", m, v & m);
  endtask : poll
  task automatic wait_got(input int n);
    int k = 0;
    while (line.got.size() < n && k < 4000) begin
      @(negedge clk);
      k++;
    end
    chk("frames", 8'(n), 8'(line.got.size()));
  endtask : wait_got
  task automatic set_div(input int dw, input logic [7:0] fmt);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'(dw));
    wr(3'h1, 8'h00);
    wr(3'h3, fmt);
  endtask : set_div
  task automatic chk_reset();
    repeat (5) @(negedge clk);
    chk("pins", 8'h1f, {3'h0, data_oe_n, tx, dtr_n, rts_n, int_oe_n});
    rdc("ier", 3'h1, 8'h00);
    rdc("isr", 3'h2, 8'h01);
    rdc("lcr", 3'h3, 8'h00);
    rdc("mcr", 3'h4, 8'h00);
    rdc("lsr", 3'h5, 8'h60);
    rdc("msr", 3'h6, 8'h00);
  endtask : chk_reset
  function automatic logic [7:0] msk(input logic [7:0] f);
    return 8'((9'h020 << f[1:0]) - 9'h001);
  endfunction : msk
  function automatic logic par(input logic [7:0] x, input logic [7:0] f);
    if (f[5]) return !f[4];
    return f[4] ? ^(x & msk(f)) : !(^(x & msk(f)));
  endfunction : par
  initial begin
    void'($urandom(32'h07c4ab6f));
    {nrst, addr, data_in} = '0;
    {cs_n, ior_n, iow_n, mdm_n} = '1;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chk_reset();
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      wr(3'h7, d);
      rdc("spr", 3'h7, d);
      wr(3'h3, 8'h80);
      wr(3'h0, ~d);
      wr(3'h1, d);
      rdc("dll", 3'h0, ~d);
      rdc("dlm", 3'h1, d);
      wr(3'h3, 8'h00);
      rdc("ier_remap", 3'h1, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      l = {2'b00, 3'($urandom), 3'(i)};
      dv = 1 + i % 2;
      set_div(dv, l);
      line.bit_cyc = 16 * dv;
      line.nbits = 5 + l[1:0];
      line.par_en = l[3];
      line.got.delete();
      line.t0.delete();
      d = 8'($urandom);
      wr(3'h0, d);
      wr(3'h0, ~d);
      rdc("lsr_full", 3'h5, 8'h00);
      wait_got(2);
      ex = dv * (16 * (6 + l[1:0] + l[3]) + (!l[2] ? 16 : (l[1:0] == 2'b00 ? 24 : 32)));
      chk("gap", 8'h01, {7'h0, (line.t0[1] - line.t0[0]) inside {[ex:ex + 2]}});
      for (int j = 0; j < 2; j++) begin
        e = (j == 0) ? d : ~d;
        chk("tx_data", e & msk(l), line.got[j][7:0]);
        chk("tx_tail", {6'h0, 1'b1, l[3] & par(e, l)}, {6'h0, line.got[j][9:8]});
      end
      repeat (40 * dv) @(negedge clk);
      rdc("lsr_idle", 3'h5, 8'h60);
      line.send(d, 5 + l[1:0], l[3], par(d, l), 1'b1);
      poll(8'h01);
      rdc("rx_data", 3'h0, d & msk(l));
      rdc("lsr_clr", 3'h5, 8'h60);
    end
    set_div(1, 8'h1b);
    line.bit_cyc = 16;
    line.low(4);
    repeat (100) @(negedge clk);
    rdc("noise", 3'h5, 8'h60);
    wr(3'h1, 8'h0f);
    wr(3'h4, 8'h08);
    chk("int_oe", 8'h00, {7'h0, int_oe_n});
    wr(3'h0, d);
    line.send(d, 8, 1'b1, !par(d, 8'h1b), 1'b1);
    line.send(~d, 8, 1'b1, par(~d, 8'h1b), 1'b0);
    repeat (4) @(negedge clk);
    chk("int_pin", 8'h01, {7'h0, int_out});
    rdc("isr_line", 3'h2, 8'h06);
    rdc("lsr_err", 3'h5, 8'h6f);
    rdc("isr_rx", 3'h2, 8'h04);
    acc(1'b0, 3'h0, 8'h00);
    rdc("isr_thr", 3'h2, 8'h02);
    rdc("isr_none", 3'h2, 8'h01);
    mdm_n[0] = 1'b0;
    repeat (3) @(negedge clk);
    rdc("isr_modem", 3'h2, 8'h00);
    rdc("msr_cts", 3'h6, 8'h11);
    for (int i = 0; i < 6; i++) begin
      p = mdm_n;
      mdm_n = 4'($urandom);
      repeat (3) @(negedge clk);
      rdc("msr", 3'h6, {~mdm_n, ((p ^ mdm_n) & 4'hb) | {1'b0, !p[2] & mdm_n[2], 2'b0}});
    end
    wr(3'h1, 8'h08);
    wr(3'h4, 8'h10);
    acc(1'b0, 3'h6, 8'h00);
    wr(3'h4, 8'h11);
    mdm_n = ~mdm_n;
    repeat (3) @(negedge clk);
    rdc("isr_loop", 3'h2, 8'h00);
    rdc("msr_loop", 3'h6, 8'h22);
    wr(3'h0, d);
    poll(8'h01);
    rdc("loop_rx", 3'h0, d);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h04);
    chk("srst_off", 8'h00, {7'h0, rst_out});
    wr(3'h1, 8'h20);
    chk("srst_on", 8'h01, {7'h0, rst_out});
    line.low(16 * 12);
    poll(8'h10);
    acc(1'b0, 3'h0, 8'h00);
    wr(3'h4, 8'h80);
    wr(3'h0, d);
    repeat (400) @(negedge clk);
    rdc("pdown", 3'h5, 8'h20);
    wr(3'h4, 8'h00);
    repeat (300) @(negedge clk);
    rdc("pdown_off", 3'h5, 8'h60);
    wr(3'h3, 8'h43);
    chk("break", 8'h00, {7'h0, tx});
    repeat (8) @(negedge clk);
    wr(3'h3, 8'h03);
    mdm_n = 4'hf;
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chk_reset();
    give_verdict();
  end
endmodule : asmc_top_tb
